/* File: pkg/surge_pkg.sv */
// shared constants, register map and carrier types of the surge monitor
package surge_pkg;

  // clock and time base
  localparam int CLK_HZ = 250_000_000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
  localparam int MINUTE_S = 60;
  localparam int EXT_RUN_S = 600;

  // setting ranges and defaults
  localparam logic [7:0] WIN_MIN = 8'h01;
  localparam logic [7:0] WIN_MAX = 8'h05;
  localparam logic [7:0] WIN_DEF = 8'h03;
  localparam logic [7:0] LIM_MIN = 8'h04;
  localparam logic [7:0] LIM_MAX = 8'h14;
  localparam logic [7:0] LIM_DEF = 8'h0F;
  // sensitivity in tenths: 0.3 .. 1.3
  localparam logic [7:0] SENS_MIN = 8'h03;
  localparam logic [7:0] SENS_MAX = 8'h0D;
  localparam logic [7:0] SENS_DEF = 8'h03;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_WIN_LEN = 8'h08;
  localparam logic [7:0] OFS_LIMIT = 8'h0C;
  localparam logic [7:0] OFS_SENS = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_WIN_TIME = 8'h18;
  localparam logic [7:0] OFS_WIN_COUNT = 8'h1C;
  localparam logic [7:0] OFS_TOTAL = 8'h20;
  localparam logic [7:0] OFS_EXT_REMAIN = 8'h24;
  localparam logic [7:0] OFS_RATIO = 8'h28;

  // field layout
  localparam int CTRL_W = 4;
  localparam int CMD_CLR_TOTAL = 0;
  localparam int CMD_WARN_RST = 1;
  localparam int RATIO_FRAC = 8;
  localparam int SET_W = 8;

  // control bits, shutdown_en in bit 0
  typedef struct packed {
    logic drive_fitted;
    logic hgb_en;
    logic ext_run_en;
    logic shutdown_en;
  } cfg_s;

  localparam cfg_s CFG_DEF = 4'h0;

  // plant-side levels and the surge event pulse
  typedef struct packed {
    logic surge;
    logic running;
    logic at_max;
    logic valve_open;
  } plant_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_EXT = 2'h2
  } run_state_e;

endpackage : surge_pkg

/* File: src/surge_slot_mem.sv */
// per-minute surge count slots with registered read
`timescale 1ns/10ps
module surge_slot_mem #(
  parameter int DEPTH = 5,
  parameter int WIDTH = 8,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : surge_slot_mem

/* File: src/surge_excess_monitor.sv */
// surge protection supervisor: rolling window, limit actions, totals
//
// Contract
// - rolling total drops oldest, adds newest minute
// - window time counts up, zeroed at shutdown
// - window count partial early, cleared at shutdown
// - window length one to five, default three
// - limit 4 to 20, excess when above
// - both disabled: keep running, raise warning
// - shutdown only: request shutdown on excess
// - extended run: close vanes ten minutes, warn
// - run end clears inhibit if count ok
// - both enabled: shutdown if still excess
// - no shutdown: latch detect warning until reset
// - show remaining extended run time
// - hot gas enabled: valve fully open first; shutdown and warnings wait for the valve only with a drive fitted
// - drive fitted: full speed first
// - both present: both conditions together
// - drive fitted: gate shutdown and warnings
// - indicator pulses per surge, drive at max
// - lifetime total, only max-speed surges
// - clear command zeroes lifetime total
// - sensitivity 0.3 to 1.3, default 0.3
// - capacity-control indicator below max speed
// - head ratio (cond - evap) / evap
`timescale 1ns/10ps
module surge_excess_monitor #(
  parameter int TICK_CYCLES = surge_pkg::TICK_CYCLES,
  parameter int WIN_DEPTH = 5,
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  input wire surge_pkg::plant_s plant,
  input wire logic [15:0] cond_press,
  input wire logic [15:0] evap_press,
  output logic shutdown_req,
  output logic vane_close,
  output logic limit_warn,
  output logic detect_warn,
  output logic surge_ind,
  output logic cap_surge_ind,
  output logic [7:0] sens_out
);
  localparam int AW = 3;
  localparam logic [5:0] SEC_LAST = 6'(surge_pkg::MINUTE_S - 1);
  localparam logic [9:0] EXT_LOAD = 10'(surge_pkg::EXT_RUN_S);
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
  localparam int DIV_STEPS = 16 + surge_pkg::RATIO_FRAC;
  function automatic logic [7:0] clamp8(input logic [7:0] v,
                                        input logic [7:0] lo,
                                        input logic [7:0] hi);
    clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp8
  // register file state
  surge_pkg::cfg_s cfg_reg;
  logic [2:0] win_len_reg;
  logic [7:0] limit_reg;
  logic [7:0] sens_reg;
  logic [31:0] total_reg;
  // bus decode
  wire wr_ctrl = wr_stb && addr == surge_pkg::OFS_CTRL;
  wire wr_cmd = wr_stb && addr == surge_pkg::OFS_CMD;
  wire wr_win = wr_stb && addr == surge_pkg::OFS_WIN_LEN;
  wire wr_lim = wr_stb && addr == surge_pkg::OFS_LIMIT;
  wire wr_sens = wr_stb && addr == surge_pkg::OFS_SENS;
  wire clr_total = wr_cmd && wdata[surge_pkg::CMD_CLR_TOTAL];
  wire warn_rst = wr_cmd && wdata[surge_pkg::CMD_WARN_RST];
  wire [7:0] win_w = clamp8(wdata[7:0], surge_pkg::WIN_MIN,
                            surge_pkg::WIN_MAX);
  wire [7:0] lim_w = clamp8(wdata[7:0], surge_pkg::LIM_MIN,
                            surge_pkg::LIM_MAX);
  wire [7:0] sens_w = clamp8(wdata[7:0], surge_pkg::SENS_MIN,
                             surge_pkg::SENS_MAX);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg_reg <= surge_pkg::CFG_DEF;
      win_len_reg <= surge_pkg::WIN_DEF[2:0];
      limit_reg <= surge_pkg::LIM_DEF;
      sens_reg <= surge_pkg::SENS_DEF;
    end else begin
      if (wr_ctrl) cfg_reg <= surge_pkg::cfg_s'(wdata[surge_pkg::CTRL_W-1:0]);
      if (wr_win) win_len_reg <= win_w[2:0];
      if (wr_lim) limit_reg <= lim_w;
      if (wr_sens) sens_reg <= sens_w;
    end
  end
  // one-second tick
  logic [31:0] tick_cnt_reg;
  wire tick = tick_cnt_reg == TICK_LAST;
  always_ff @(posedge clk) begin
    if (!rst_b) tick_cnt_reg <= '0;
    else tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 32'h1;
  end
  // surge qualification
  wire running = plant.running;
  wire evt = plant.surge && running;
  wire at_max_ok = !cfg_reg.drive_fitted || plant.at_max;
  wire valve_ok = !cfg_reg.hgb_en || plant.valve_open;
  wire qual_evt = evt && at_max_ok;
  wire cap_evt = evt && cfg_reg.drive_fitted && !plant.at_max;
  // shutdown and warnings only wait for the valve when a drive is fitted
  wire gate_ok = !cfg_reg.drive_fitted ||
                 (plant.at_max && valve_ok);
  wire start_ok = at_max_ok && valve_ok;
  // rolling window; a length change restarts it to keep slots coherent
  logic [5:0] sec_reg;
  logic [2:0] elapsed_reg;
  logic [AW-1:0] wptr_reg;
  logic [CNT_W-1:0] cur_reg;
  logic [CNT_W-1:0] win_cnt_reg;
  logic [CNT_W-1:0] old_cnt;
  wire win_clr = !running || wr_win;
  wire minute = running && tick && sec_reg == SEC_LAST;
  wire full = elapsed_reg == win_len_reg;
  wire [CNT_W-1:0] evt_w = CNT_W'(evt);
  wire [CNT_W-1:0] slot_w = cur_reg + evt_w;
  wire [CNT_W-1:0] drop = (minute && full) ? old_cnt : '0;
  wire [AW-1:0] wptr_last = win_len_reg - 3'h1;
  wire excess = win_cnt_reg > limit_reg;
  surge_slot_mem #(
    .DEPTH(WIN_DEPTH),
    .WIDTH(CNT_W),
    .AW(AW)
  ) u_slots (
    .clk(clk),
    .we(minute),
    .waddr(wptr_reg),
    .wdata(slot_w),
    .raddr(wptr_reg),
    .rdata(old_cnt)
  );
  always_ff @(posedge clk) begin
    if (!rst_b || win_clr) begin
      sec_reg <= '0;
      elapsed_reg <= '0;
      wptr_reg <= '0;
      cur_reg <= '0;
      win_cnt_reg <= '0;
    end else begin
      if (tick) sec_reg <= (sec_reg == SEC_LAST) ? '0 : sec_reg + 6'h1;
      if (minute) begin
        if (!full) elapsed_reg <= elapsed_reg + 3'h1;
        wptr_reg <= (wptr_reg == wptr_last) ? '0 : wptr_reg + 3'h1;
        cur_reg <= '0;
      end else begin
        cur_reg <= slot_w;
      end
      win_cnt_reg <= win_cnt_reg + evt_w - drop;
    end
  end
  // excess surge actions
  surge_pkg::run_state_e state_reg;
  logic [9:0] remain_reg;
  wire sd_en = cfg_reg.shutdown_en;
  wire er_en = cfg_reg.ext_run_en;
  wire idle_excess = state_reg == surge_pkg::ST_IDLE && running && excess;
  wire ext_start = idle_excess && er_en && start_ok;
  wire ext_end = state_reg == surge_pkg::ST_EXT && tick &&
                 remain_reg == 10'h1;
  always_ff @(posedge clk) begin
    if (!rst_b || !running) begin
      state_reg <= surge_pkg::ST_IDLE;
      remain_reg <= '0;
      vane_close <= 1'b0;
      limit_warn <= 1'b0;
    end else begin
      case (state_reg)
        surge_pkg::ST_IDLE: begin
          if (ext_start) begin
            state_reg <= surge_pkg::ST_EXT;
            remain_reg <= EXT_LOAD;
            vane_close <= 1'b1;
            limit_warn <= 1'b1;
          end
        end
        surge_pkg::ST_EXT: begin
          if (ext_end && !excess) begin
            state_reg <= surge_pkg::ST_IDLE;
            remain_reg <= '0;
            vane_close <= 1'b0;
            limit_warn <= 1'b0;
          end else if (ext_end && sd_en) begin
            state_reg <= surge_pkg::ST_IDLE;
            remain_reg <= '0;
          end else if (ext_end) begin
            // still excess without shutdown: another full period
            remain_reg <= EXT_LOAD;
          end else if (tick) begin
            remain_reg <= remain_reg - 10'h1;
          end
        end
        default: begin
          state_reg <= surge_pkg::ST_IDLE;
        end
      endcase
    end
  end
  // shutdown request holds until the chiller stops
  wire sd_direct = idle_excess && sd_en && !er_en && gate_ok;
  wire sd_after = ext_end && excess && sd_en && gate_ok;
  wire warn_only = idle_excess && !sd_en && !er_en && gate_ok;
  wire warn_ext = ext_start && !sd_en && gate_ok;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      shutdown_req <= 1'b0;
      detect_warn <= 1'b0;
    end else begin
      if (sd_direct || sd_after) shutdown_req <= 1'b1;
      else if (!running) shutdown_req <= 1'b0;
      // a new excess wins over a warning reset in the same cycle
      if (warn_only || warn_ext) detect_warn <= 1'b1;
      else if (warn_rst) detect_warn <= 1'b0;
    end
  end
  // indicators and lifetime total
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      surge_ind <= 1'b0;
      cap_surge_ind <= 1'b0;
      total_reg <= '0;
      sens_out <= surge_pkg::SENS_DEF;
    end else begin
      surge_ind <= qual_evt;
      cap_surge_ind <= cap_evt;
      sens_out <= sens_reg;
      if (qual_evt) total_reg <= total_reg + 32'h1;
      else if (clr_total) total_reg <= '0;
    end
  end
  // head ratio in 8.8 fixed point, serial restoring divide
  logic [15:0] ratio_reg;
  logic [23:0] quo_reg;
  logic [16:0] rem_reg;
  logic [15:0] den_reg;
  logic [4:0] step_reg;
  wire [15:0] diff = (cond_press > evap_press) ?
                     cond_press - evap_press : '0;
  wire [16:0] rem_sh = {rem_reg[15:0], quo_reg[23]};
  wire rem_ge = rem_sh >= {1'b0, den_reg};
  wire div_done = step_reg == 5'(DIV_STEPS + 1);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ratio_reg <= '0;
      quo_reg <= '0;
      rem_reg <= '0;
      den_reg <= '0;
      step_reg <= '0;
    end else if (step_reg == '0) begin
      quo_reg <= {diff, 8'h00};
      rem_reg <= '0;
      den_reg <= evap_press;
      step_reg <= 5'h1;
    end else if (div_done) begin
      // zero evaporator pressure or overflow saturates
      if (den_reg == '0 || quo_reg[23:16] != '0) ratio_reg <= 16'hFFFF;
      else ratio_reg <= quo_reg[15:0];
      step_reg <= '0;
    end else begin
      rem_reg <= rem_ge ? rem_sh - {1'b0, den_reg} : rem_sh;
      quo_reg <= {quo_reg[22:0], rem_ge};
      step_reg <= step_reg + 5'h1;
    end
  end
  // read port: data only in the cycle after the strobe
  logic [31:0] rd_mux;
  wire [31:0] status_w = {26'h0, state_reg, detect_warn, limit_warn,
                          vane_close, shutdown_req};
  always_comb begin
    case (addr)
      surge_pkg::OFS_CTRL: rd_mux = {28'h0, cfg_reg};
      surge_pkg::OFS_WIN_LEN: rd_mux = {29'h0, win_len_reg};
      surge_pkg::OFS_LIMIT: rd_mux = {24'h0, limit_reg};
      surge_pkg::OFS_SENS: rd_mux = {24'h0, sens_reg};
      surge_pkg::OFS_STATUS: rd_mux = status_w;
      surge_pkg::OFS_WIN_TIME: rd_mux = {29'h0, elapsed_reg};
      surge_pkg::OFS_WIN_COUNT: rd_mux = {24'h0, win_cnt_reg};
      surge_pkg::OFS_TOTAL: rd_mux = total_reg;
      surge_pkg::OFS_EXT_REMAIN: rd_mux = {22'h0, remain_reg};
      surge_pkg::OFS_RATIO: rd_mux = {16'h0, ratio_reg};
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_b) rdata <= '0;
    else rdata <= rd_stb ? rd_mux : 32'h0;
  end
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_ext_entry;
    ext_start;
  endsequence
  sequence s_ext_on;
    vane_close && limit_warn && remain_reg == EXT_LOAD;
  endsequence
  property p_win_clear;
    !running |=> win_cnt_reg == '0 && elapsed_reg == '0;
  endproperty
  a_win_clear: assert property (p_win_clear)
    else $error("window not cleared at shutdown");
  property p_win_drop;
    minute && full && !evt && !wr_win |=>
      win_cnt_reg == $past(win_cnt_reg) - $past(old_cnt);
  endproperty
  a_win_drop: assert property (p_win_drop)
    else $error("oldest minute not dropped");
  property p_len_range;
    win_len_reg >= surge_pkg::WIN_MIN[2:0] &&
    win_len_reg <= surge_pkg::WIN_MAX[2:0] && elapsed_reg <= win_len_reg;
  endproperty
  a_len_range: assert property (p_len_range)
    else $error("window length or time out of range");
  property p_limit_range;
    limit_reg >= surge_pkg::LIM_MIN && limit_reg <= surge_pkg::LIM_MAX;
  endproperty
  a_limit_range: assert property (p_limit_range)
    else $error("limit out of range");
  property p_warn_only;
    warn_only |=> detect_warn && !vane_close && !shutdown_req;
  endproperty
  a_warn_only: assert property (p_warn_only)
    else $error("warning-only action wrong");
  property p_sd_direct;
    sd_direct |=> shutdown_req && !vane_close;
  endproperty
  a_sd_direct: assert property (p_sd_direct)
    else $error("no shutdown on excess");
  // a stop right after entry legally drops the inhibit
  property p_ext_start;
    s_ext_entry ##1 running |-> s_ext_on ##1 (vane_close && limit_warn);
  endproperty
  a_ext_start: assert property (p_ext_start)
    else $error("extended run did not start");
  property p_ext_clear;
    ext_end && !excess && running |=> !vane_close && !limit_warn;
  endproperty
  a_ext_clear: assert property (p_ext_clear)
    else $error("inhibit not cleared after run");
  property p_ext_sd;
    sd_after && running |=> shutdown_req;
  endproperty
  a_ext_sd: assert property (p_ext_sd)
    else $error("no shutdown after extended run");
  property p_ext_gate;
    state_reg == surge_pkg::ST_IDLE ##1 state_reg == surge_pkg::ST_EXT
      |-> $past(start_ok);
  endproperty
  a_ext_gate: assert property (p_ext_gate)
    else $error("extended run started without conditions");
  property p_total;
    qual_evt |=> total_reg == $past(total_reg) + 32'h1 && surge_ind;
  endproperty
  a_total: assert property (p_total)
    else $error("surge not counted or shown");
  property p_clear;
    clr_total && !qual_evt |=> total_reg == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("total not cleared");
endmodule : surge_excess_monitor

/* File: bench/plant_model.sv */
// chiller sequencer, drive and valve stand-in feeding the plant levels
`timescale 1ns/10ps
module plant_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run_lvl,
  input wire logic max_lvl,
  input wire logic valve_lvl,
  input wire logic surge_go,
  input wire logic shutdown_req,
  output surge_pkg::plant_s plant
);
  logic trip_reg;
  // a safety shutdown stops the chiller until the run command drops
  always_ff @(posedge clk) begin
    if (!rst_b || !run_lvl) begin
      trip_reg <= 1'b0;
    end else if (shutdown_req) begin
      trip_reg <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    plant.surge <= surge_go && rst_b;
    plant.running <= run_lvl && !trip_reg && !shutdown_req;
    plant.at_max <= max_lvl;
    plant.valve_open <= valve_lvl;
  end
endmodule : plant_model

/* File: bench/testbench.sv */
// self-checking bench for the surge monitor
`timescale 1ns/10ps
module testbench;
  localparam int TICKS = 10;
  logic clk, rst_b, wr_stb, rd_stb, sd_q, rd_pend;
  logic [7:0] addr, sens_out;
  logic [31:0] wdata, rdata, v;
  logic run_lvl, max_lvl, valve_lvl, surge_go;
  logic [15:0] cond_press, evap_press;
  logic shutdown_req, vane_close, limit_warn, detect_warn;
  logic surge_ind, cap_surge_ind;
  surge_pkg::plant_s plant;
  logic [40:0] exp_q[$];
  logic [40:0] note;
  logic [7:0] ca [7] = '{8'h08, 8'h08, 8'h0C, 8'h0C, 8'h10, 8'h10, 8'h08};
  logic [7:0] wd [7] = '{8'h00, 8'h09, 8'h02, 8'h1E, 8'h00, 8'h14, 8'h02};
  logic [7:0] ce [7] = '{8'h01, 8'h05, 8'h04, 8'h14, 8'h03, 8'h0D, 8'h02};
  int num_errors, cmp_count, cyc, n_ind, n_cap, n_sd, n1, n2, t0, k;
  logic [15:0] ev, cv;

  surge_excess_monitor #(.TICK_CYCLES(TICKS)) surge_excess_monitor_inst (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .plant(plant),
    .cond_press(cond_press), .evap_press(evap_press),
    .shutdown_req(shutdown_req), .vane_close(vane_close),
    .limit_warn(limit_warn), .detect_warn(detect_warn),
    .surge_ind(surge_ind), .cap_surge_ind(cap_surge_ind),
    .sens_out(sens_out));

  plant_model plant_model_inst (
    .clk(clk), .rst_b(rst_b), .run_lvl(run_lvl), .max_lvl(max_lvl),
    .valve_lvl(valve_lvl), .surge_go(surge_go),
    .shutdown_req(shutdown_req), .plant(plant));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, want, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr

  // c low: value only wanted in v, no comparison
  task automatic rd(input logic [7:0] a, input logic c,
                    input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    exp_q.push_back({c, a, e});
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask : rd

  task automatic wait_reg(input logic [7:0] a, input logic [31:0] w);
    k = 0;
    do begin
      rd(a, 1'b0, 32'h0);
      k++;
    end while (v !== w && k < 800);
    check("wait_reg", v, w);
  endtask : wait_reg

  task automatic go(input logic r, input logic m, input logic vo);
    @(posedge clk);
    run_lvl <= r;
    max_lvl <= m;
    valve_lvl <= vo;
  endtask : go

  task automatic surges(input int n);
    repeat (n) begin
      @(posedge clk);
      surge_go <= 1'b1;
      @(posedge clk);
      surge_go <= 1'b0;
    end
  endtask : surges

  task automatic wait_vane(input logic l);
    k = 0;
    while (vane_close !== l && k < 7000) begin
      @(posedge clk);
      k++;
    end
  endtask : wait_vane

  // read answers are matched against the oldest note
  always @(posedge clk) begin
    if (rd_pend) begin
      note = exp_q.pop_front();
      if (note[40])
        check($sformatf("reg %h", note[39:32]), rdata, note[31:0]);
    end
    rd_pend <= rd_stb;
    if (surge_ind === 1'b1) n_ind++;
    if (cap_surge_ind === 1'b1) n_cap++;
    if (shutdown_req === 1'b1 && !sd_q) n_sd++;
    sd_q <= (shutdown_req === 1'b1);
    if (rst_b && vane_close !== limit_warn)
      check("limit_warn", 32'(limit_warn), 32'(vane_close));
    cyc++;
    if (cyc == 25000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    {rst_b, wr_stb, rd_stb, run_lvl, max_lvl, valve_lvl, surge_go} = 7'h00;
    {sd_q, rd_pend} = 2'h0;
    addr = 8'h00;
    wdata = 32'h0;
    cond_press = 16'h0200;
    evap_press = 16'h0100;
    void'($urandom(32'h4284EBA0));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    check("sens_out", 32'(sens_out), 32'h3);
    rd(surge_pkg::OFS_CTRL, 1'b1, 32'h0);
    rd(surge_pkg::OFS_WIN_LEN, 1'b1, 32'h3);
    rd(surge_pkg::OFS_LIMIT, 1'b1, 32'hF);
    rd(surge_pkg::OFS_SENS, 1'b1, 32'h3);
    rd(surge_pkg::OFS_STATUS, 1'b1, 32'h10);
    rd(surge_pkg::OFS_TOTAL, 1'b1, 32'h0);
    rd(8'h30, 1'b1, 32'h0);
    for (int i = 0; i < 7; i++) begin
      wr(ca[i], 32'(wd[i]));
      rd(ca[i], 1'b1, 32'(ce[i]));
    end
    check("sens_out", 32'(sens_out), 32'hD);
    // drive fitted: split of surges by drive speed
    wr(surge_pkg::OFS_CTRL, 32'h8);
    surges(2);
    go(1'b1, 1'b1, 1'b0);
    n1 = 1 + $urandom % 3;
    n2 = 1 + $urandom % 3;
    surges(n1);
    go(1'b1, 1'b0, 1'b0);
    surges(n2);
    rd(surge_pkg::OFS_TOTAL, 1'b1, 32'(n1));
    rd(surge_pkg::OFS_WIN_COUNT, 1'b1, 32'(n1 + n2));
    check("surge_ind", 32'(n_ind), 32'(n1));
    check("cap_surge_ind", 32'(n_cap), 32'(n2));
    wr(surge_pkg::OFS_CMD, 32'h1);
    rd(surge_pkg::OFS_TOTAL, 1'b1, 32'h0);
    go(1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    rd(surge_pkg::OFS_WIN_COUNT, 1'b1, 32'h0);
    rd(surge_pkg::OFS_WIN_TIME, 1'b1, 32'h0);
    // warning only, two minute window
    wr(surge_pkg::OFS_CTRL, 32'h0);
    wr(surge_pkg::OFS_LIMIT, 32'h4);
    go(1'b1, 1'b1, 1'b0);
    surges(3);
    wait_reg(surge_pkg::OFS_WIN_TIME, 32'h1);
    surges(1);
    rd(surge_pkg::OFS_WIN_COUNT, 1'b1, 32'h4);
    rd(surge_pkg::OFS_STATUS, 1'b1, 32'h10);
    wait_reg(surge_pkg::OFS_WIN_TIME, 32'h2);
    wait_reg(surge_pkg::OFS_WIN_COUNT, 32'h1);
    rd(surge_pkg::OFS_WIN_TIME, 1'b1, 32'h2);
    surges(4);
    // the warning lands one edge after the last pulse is counted
    @(posedge clk);
    rd(surge_pkg::OFS_STATUS, 1'b1, 32'h18);
    check("detect_warn", 32'(detect_warn), 32'h1);
    go(1'b0, 1'b0, 1'b0);
    rd(surge_pkg::OFS_STATUS, 1'b1, 32'h18);
    wr(surge_pkg::OFS_CMD, 32'h2);
    rd(surge_pkg::OFS_STATUS, 1'b1, 32'h10);
    // shutdown only, drive fitted
    wr(surge_pkg::OFS_CTRL, 32'h9);
    go(1'b1, 1'b0, 1'b0);
    surges(5);
    rd(surge_pkg::OFS_STATUS, 1'b1, 32'h10);
    n1 = n_sd;
    go(1'b1, 1'b1, 1'b0);
    repeat (6) @(posedge clk);
    check("shutdown", 32'(n_sd - n1), 32'h1);
    rd(surge_pkg::OFS_WIN_COUNT, 1'b1, 32'h0);
    rd(surge_pkg::OFS_WIN_TIME, 1'b1, 32'h0);
    // extended run with hot gas and drive gating
    go(1'b0, 1'b0, 1'b0);
    wr(surge_pkg::OFS_CTRL, 32'hE);
    wr(surge_pkg::OFS_WIN_LEN, 32'h1);
    go(1'b1, 1'b1, 1'b0);
    surges(5);
    rd(surge_pkg::OFS_STATUS, 1'b1, 32'h10);
    go(1'b1, 1'b1, 1'b1);
    wait_vane(1'b1);
    t0 = cyc;
    rd(surge_pkg::OFS_STATUS, 1'b1, 32'h2E);
    rd(surge_pkg::OFS_EXT_REMAIN, 1'b0, 32'h0);
    check("remain", 32'(v >= 32'd599 && v <= 32'd600), 32'h1);
    repeat (1000) @(posedge clk);
    rd(surge_pkg::OFS_EXT_REMAIN, 1'b0, 32'h0);
    check("remain", 32'(v >= 32'd498 && v <= 32'd500), 32'h1);
    wait_vane(1'b0);
    check("ext_len", 32'(cyc - t0 >= 5985 && cyc - t0 <= 6010),
          32'h1);
    rd(surge_pkg::OFS_STATUS, 1'b1, 32'h18);
    wr(surge_pkg::OFS_CMD, 32'h2);
    rd(surge_pkg::OFS_STATUS, 1'b1, 32'h10);
    check("detect_warn", 32'(detect_warn), 32'h0);
    // extended run then shutdown while surging persists
    wr(surge_pkg::OFS_CTRL, 32'hB);
    wr(surge_pkg::OFS_WIN_LEN, 32'h5);
    go(1'b1, 1'b0, 1'b0);
    surges(5);
    rd(surge_pkg::OFS_STATUS, 1'b1, 32'h10);
    n1 = n_sd;
    go(1'b1, 1'b1, 1'b0);
    wait_vane(1'b1);
    rd(surge_pkg::OFS_STATUS, 1'b1, 32'h26);
    for (int i = 0; i < 14 && n_sd == n1; i++) begin
      repeat (480) @(posedge clk);
      surges(5);
    end
    check("shutdown", 32'(n_sd - n1), 32'h1);
    go(1'b0, 1'b0, 1'b0);
    // head ratio, 8.8 fixed point, truncated
    for (int i = 0; i < 4; i++) begin
      ev = 16'h0100 + 16'($urandom % 256);
      cv = ev + 16'($urandom % 1024);
      @(posedge clk);
      evap_press <= ev;
      cond_press <= cv;
      // a divide already running on old inputs must finish first
      repeat (60) @(posedge clk);
      rd(surge_pkg::OFS_RATIO, 1'b1,
         ((32'(cv - ev)) << 8) / 32'(ev));
    end
    @(posedge clk);
    evap_press <= 16'h0000;
    repeat (60) @(posedge clk);
    rd(surge_pkg::OFS_RATIO, 1'b1, 32'hFFFF);
    repeat (2) @(posedge clk);
    end_of_test();
  end
endmodule : testbench
